// ---- include/aur_pkg.sv ----
/*
 * Constants, register map and state type of the asynchronous receiver.
 * Assumes a 16x baud tick from an external baud rate generator.
 */
package aur_pkg;

    // ************************************************************
    // Register bus
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DATA   = 8'h08;
    localparam logic [DATA_W-1:0] CTRL_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO   = 8'h00;

    // Control bits
    localparam int CTRL_PORT_EN  = 0;
    localparam int CTRL_RX_EN    = 1;
    localparam int CTRL_NINE     = 2;
    localparam int CTRL_ADDR_DET = 3;
    localparam int CTRL_SYNC     = 4;
    localparam int CTRL_RX_IE    = 5;
    localparam int CTRL_PER_IE   = 6;
    localparam int CTRL_GLB_IE   = 7;

    // Status bits
    localparam int STAT_NINTH = 0;
    localparam int STAT_OVR   = 1;
    localparam int STAT_FRAME = 2;
    localparam int STAT_IDLE  = 3;
    localparam int STAT_FLAG  = 4;

    // ************************************************************
    // Character entry and timing
    // ************************************************************
    localparam int ENTRY_W    = 10;
    localparam int ENT_NINTH  = 8;
    localparam int ENT_FRAME  = 9;
    localparam int FIFO_DEPTH = 2;
    localparam int OVERSAMPLE = 16;

    localparam logic [3:0] SAMPLE_FIRST = 4'h7;
    localparam logic [3:0] SAMPLE_MID   = 4'h8;
    localparam logic [3:0] SAMPLE_LAST  = 4'h9;
    localparam logic [3:0] LAST_BIT_8   = 4'h7;
    localparam logic [3:0] LAST_BIT_9   = 4'h8;

    typedef enum logic [1:0] {
        AUR_IDLE,
        AUR_START,
        AUR_DATA,
        AUR_STOP
    } aur_state_t;

endpackage : aur_pkg

// ---- include/aur_fifo_if.sv ----
/*
 * Link between the receiver core and its character store.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface aur_fifo_if #(parameter int W = 10);
    logic         push;
    logic [W-1:0] wdata;
    logic         pop;
    logic         flush;
    logic [W-1:0] head;
    logic         empty;
    logic         full;

    modport producer (output push, wdata, pop, flush,
                      input  head, empty, full);
    modport store    (input  push, wdata, pop, flush,
                      output head, empty, full);
endinterface : aur_fifo_if

// ---- logic/aur_sync.sv ----
/*
 * Two-flop synchroniser for the receive pin.
 * Assumes the pin idles high, so both flops reset high.
 */
`timescale 1ns/1ps
module aur_sync
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta  <= 1'b1;
            q_out <= 1'b1;
        end
        else
        begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule : aur_sync

// ---- logic/aur_fifo.sv ----
/*
 * Character store: each entry keeps data, ninth bit and framing bit.
 * Assumes the producer never pushes while full nor pops while empty.
 */
`timescale 1ns/1ps
module aur_fifo #(
    parameter int DEPTH = 2,
    parameter int W     = 10
)
(
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    aur_fifo_if.store   port
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2)
        $error("aur_fifo needs at least two entries");

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    assign port.empty = (count == '0);
    assign port.full  = (count == CW'(DEPTH));
    assign port.head  = mem[rptr];

    always_ff @(posedge clk_in)
    begin
        if (port.push)
            mem[wptr] <= port.wdata;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end
        else if (port.flush)
        begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end
        else
        begin
            if (port.push)
                wptr <= bump(wptr);
            if (port.pop)
                rptr <= bump(rptr);
            if (port.push && !port.pop)
                count <= CW'(count + 1'b1);
            else if (port.pop && !port.push)
                count <= CW'(count - 1'b1);
        end
    end
endmodule : aur_fifo

// ---- logic/aur_receiver.sv ----
/*
 * Asynchronous serial receiver with a small character store,
 * framing and overrun status, nine-bit and address-detect modes.
 * Assumes baud_tick_in is a one-cycle pulse at 16x the bit rate,
 * made on clk_in; the receive pin is asynchronous.
 */
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module aur_receiver #(
    parameter int FIFO_DEPTH = aur_pkg::FIFO_DEPTH
)
(
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       receive_pin_in,
    input  wire logic                       baud_tick_in,
    input  wire logic [aur_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [aur_pkg::DATA_W-1:0] reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    output logic      [aur_pkg::DATA_W-1:0] reg_rdata_out,
    output logic                            receive_flag_out,
    output logic                            receive_irq_out
);

    // ************************************************************
    // Control register
    // ************************************************************
    logic [aur_pkg::DATA_W-1:0] ctrl;
    logic port_en;
    logic rx_en;
    logic nine;
    logic addr_det;
    logic run;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            ctrl <= aur_pkg::CTRL_RESET;
        else if (reg_wr_in && reg_addr_in == aur_pkg::ADDR_CTRL)
            ctrl <= reg_wdata_in;
    end

    assign port_en  = ctrl[aur_pkg::CTRL_PORT_EN];
    assign rx_en    = ctrl[aur_pkg::CTRL_RX_EN];
    assign nine     = ctrl[aur_pkg::CTRL_NINE];
    assign addr_det = ctrl[aur_pkg::CTRL_ADDR_DET];
    assign run      = port_en && rx_en && !ctrl[aur_pkg::CTRL_SYNC];

    // ************************************************************
    // Pin sampling and oversampling phase
    // ************************************************************
    logic                rx_s;
    logic                rx_prev;
    logic                fall;
    logic [3:0]          phase;
    logic                v0;
    logic                v1;
    logic                eval;
    logic                vote;
    aur_pkg::aur_state_t state;

    aur_sync u_sync
    (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (receive_pin_in),
        .q_out  (rx_s)
    );

    function automatic logic majority(input logic a, b, c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction : majority

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            rx_prev <= 1'b1;
        else
            rx_prev <= rx_s;
    end

    assign fall = rx_prev && !rx_s;

    // Phase wraps every sixteen ticks, so one bit time per wrap
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            phase <= '0;
        else if (state == aur_pkg::AUR_IDLE)
            phase <= '0;
        else if (baud_tick_in)
            phase <= 4'(phase + 1'b1);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            v0 <= 1'b1;
            v1 <= 1'b1;
        end
        else if (baud_tick_in)
        begin
            if (phase == aur_pkg::SAMPLE_FIRST)
                v0 <= rx_s;
            if (phase == aur_pkg::SAMPLE_MID)
                v1 <= rx_s;
        end
    end

    assign eval = baud_tick_in && (phase == aur_pkg::SAMPLE_LAST);
    assign vote = majority(v0, v1, rx_s);

    // ************************************************************
    // Character state machine
    // ************************************************************
    logic [3:0] bit_idx;
    logic [3:0] last_bit;
    logic [8:0] shreg;

    assign last_bit = nine ? aur_pkg::LAST_BIT_9 : aur_pkg::LAST_BIT_8;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            state <= aur_pkg::AUR_IDLE;
        else if (!run)
            state <= aur_pkg::AUR_IDLE;
        else
        begin
            case (state)
                aur_pkg::AUR_IDLE:
                    if (fall)
                        state <= aur_pkg::AUR_START;
                aur_pkg::AUR_START:
                    if (eval)
                        state <= vote ? aur_pkg::AUR_IDLE
                                      : aur_pkg::AUR_DATA;
                aur_pkg::AUR_DATA:
                    if (eval && bit_idx == last_bit)
                        state <= aur_pkg::AUR_STOP;
                aur_pkg::AUR_STOP:
                    if (eval)
                        state <= aur_pkg::AUR_IDLE;
                default:
                    state <= aur_pkg::AUR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            bit_idx <= '0;
        else if (state != aur_pkg::AUR_DATA)
            bit_idx <= '0;
        else if (eval)
            bit_idx <= 4'(bit_idx + 1'b1);
    end

    // New bits enter at the top, so the first bit ends lowest
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            shreg <= '0;
        else if (state == aur_pkg::AUR_DATA && eval)
            shreg <= {vote, shreg[8:1]};
    end

    // ************************************************************
    // Hand-off to the store and overrun
    // ************************************************************
    logic                        done;
    logic [7:0]                  char_low;
    logic                        char_ninth;
    logic                        accept;
    logic                        overrun;
    logic [aur_pkg::ENTRY_W-1:0] entry;

    aur_fifo_if #(.W(aur_pkg::ENTRY_W)) fifo_if ();

    aur_fifo #(
        .DEPTH (FIFO_DEPTH),
        .W     (aur_pkg::ENTRY_W)
    ) u_fifo (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .port   (fifo_if.store)
    );

    assign done       = (state == aur_pkg::AUR_STOP) && eval && run;
    assign char_low   = nine ? shreg[7:0] : shreg[8:1];
    assign char_ninth = nine && shreg[8];
    // Stop level and ninth bit travel with the entry
    assign entry      = {!vote, char_ninth, char_low};
    // With address detect in nine-bit mode, data characters vanish here
    assign accept     = done && !(addr_det && nine && !char_ninth);

    assign fifo_if.push  = accept && !overrun && !fifo_if.full;
    assign fifo_if.wdata = entry;
    assign fifo_if.flush = !port_en;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            overrun <= 1'b0;
        else if (!port_en || !rx_en)
            overrun <= 1'b0;
        else if (accept && fifo_if.full)
            overrun <= 1'b1;
    end

    // ************************************************************
    // Register reads, flag and request
    // ************************************************************
    logic                       head_frame;
    logic                       head_ninth;
    logic [aur_pkg::DATA_W-1:0] status;
    logic                       rd_data;

    assign rd_data     = reg_rd_in && reg_addr_in == aur_pkg::ADDR_DATA;
    assign fifo_if.pop = rd_data && !fifo_if.empty;
    // Framing and ninth bit follow the oldest entry, no clearing
    assign head_frame  = !fifo_if.empty
                         && fifo_if.head[aur_pkg::ENT_FRAME];
    assign head_ninth  = !fifo_if.empty
                         && fifo_if.head[aur_pkg::ENT_NINTH];

    always_comb
    begin
        status                     = '0;
        status[aur_pkg::STAT_NINTH] = head_ninth;
        status[aur_pkg::STAT_OVR]   = overrun;
        status[aur_pkg::STAT_FRAME] = head_frame;
        status[aur_pkg::STAT_IDLE]  = state == aur_pkg::AUR_IDLE;
        status[aur_pkg::STAT_FLAG]  = receive_flag_out;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            reg_rdata_out <= aur_pkg::READ_ZERO;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                aur_pkg::ADDR_CTRL:   reg_rdata_out <= ctrl;
                aur_pkg::ADDR_STATUS: reg_rdata_out <= status;
                aur_pkg::ADDR_DATA:   reg_rdata_out <=
                    fifo_if.empty ? aur_pkg::READ_ZERO
                                  : fifo_if.head[7:0];
                default:              reg_rdata_out <= aur_pkg::READ_ZERO;
            endcase
        end
    end

    // Flag is store occupancy gated by port_en and rx_en; no status write clears it
    assign receive_flag_out = port_en && rx_en && !fifo_if.empty;
    // Framing bit plays no part in the request
    assign receive_irq_out  = receive_flag_out
                              && ctrl[aur_pkg::CTRL_RX_IE]
                              && ctrl[aur_pkg::CTRL_PER_IE]
                              && ctrl[aur_pkg::CTRL_GLB_IE];

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_start_high;
        state == aur_pkg::AUR_START && eval && vote;
    endsequence

    sequence s_start_low;
        state == aur_pkg::AUR_START && eval && !vote;
    endsequence

    sequence s_edge_seen;
        state == aur_pkg::AUR_IDLE && fall && run;
    endsequence

    chk_start_abort: assert property (
        s_start_high and run |=> state == aur_pkg::AUR_IDLE
                                 && $stable(overrun))
        else $error("false start not dropped");

    chk_start_accept: assert property (
        s_start_low and run |=> state == aur_pkg::AUR_DATA)
        else $error("valid start not accepted");

    chk_idle_status: assert property (
        s_edge_seen |=> !status[aur_pkg::STAT_IDLE])
        else $error("idle status high during reception");

    chk_flag_follow: assert property (
        fifo_if.push && run |=> receive_flag_out)
        else $error("flag not raised after store");

    chk_irq_gate: assert property (
        receive_irq_out |-> receive_flag_out && ctrl[aur_pkg::CTRL_GLB_IE]
                            && ctrl[aur_pkg::CTRL_PER_IE])
        else $error("request without enables");

    chk_overrun_set: assert property (
        accept && fifo_if.full && run |=> overrun)
        else $error("overrun not set on third character");

    chk_overrun_block: assert property (
        overrun |-> !fifo_if.push)
        else $error("character stored during overrun");

    chk_overrun_hold: assert property (
        overrun && port_en && rx_en |=> overrun)
        else $error("overrun cleared without disable");

    chk_addr_filter: assert property (
        fifo_if.push && addr_det && nine |-> fifo_if.wdata[aur_pkg::ENT_NINTH])
        else $error("data character stored in address mode");

    chk_port_reset: assert property (
        !port_en |=> fifo_if.empty && !status[aur_pkg::STAT_FRAME])
        else $error("port disable left framing status");

endmodule : aur_receiver

// ---- verification/aur_line_model.sv ----
/*
 * Remote asynchronous transmitter driving the receive line.
 * Assumes tick_in is the same 16x baud tick the receiver sees.
 */
`timescale 1ns/1ps
module aur_line_model
(
    input  wire logic clk_in,
    input  wire logic tick_in,
    output logic      line_out,
    output logic      tick_lost_out
);
    initial line_out = 1'b1;
    initial tick_lost_out = 1'b0;

    // Samples the pre-edge tick, as the receiver does
    task automatic wait_ticks(input int n);
        repeat (n)
        begin
            @(posedge clk_in);
            // Bounded: a dead tick is reported, never waited on forever
            for (int k = 0; k < 8 && tick_in !== 1'b1; k++)
                @(posedge clk_in);
            if (tick_in !== 1'b1)
                tick_lost_out <= 1'b1;
        end
    endtask : wait_ticks

    task automatic send_bit(input logic v);
        line_out <= v;
        wait_ticks(16);
    endtask : send_bit

    // Stop level selectable so framing faults can be commanded
    task automatic send_char(input logic [8:0] d, input logic nine,
                             input logic stop);
        send_bit(1'b0);
        for (int i = 0; i < (nine ? 9 : 8); i++)
            send_bit(d[i]);
        send_bit(stop);
        send_bit(1'b1);
    endtask : send_char

    // Low pulse shorter than half a bit: a false start
    task automatic glitch();
        line_out <= 1'b0;
        wait_ticks(4);
        line_out <= 1'b1;
        wait_ticks(16);
    endtask : glitch
endmodule : aur_line_model

// ---- verification/aur_receiver_test.sv ----
/*
 * Self-checking bench for the asynchronous receiver.
 * Assumes the register map of aur_pkg and a tick every fourth clock.
 */
`timescale 1ns/1ps
module aur_receiver_test;
    localparam logic [7:0] CTL = aur_pkg::ADDR_CTRL;
    localparam logic [7:0] STA = aur_pkg::ADDR_STATUS;
    localparam logic [7:0] DAT = aur_pkg::ADDR_DATA;

    logic       clk_in    = 1'b0;
    logic       rst_in    = 1'b1;
    logic       pin;
    logic       tick      = 1'b0;
    logic [1:0] tick_div  = 2'h0;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic       flag;
    logic       irq;
    logic       tick_lost;
    int         num_errors   = 0;
    int         total_checks = 0;
    logic [7:0] masks [4] = '{8'h23, 8'h43, 8'h83, 8'hE3};

    initial
    begin
        forever #2 clk_in = ~clk_in;
    end

    always_ff @(posedge clk_in)
    begin
        tick_div <= tick_div + 2'h1;
        tick     <= (tick_div == 2'h2);
    end

    aur_receiver u_dut (
        .clk_in          (clk_in),
        .rst_in          (rst_in),
        .receive_pin_in  (pin),
        .baud_tick_in    (tick),
        .reg_addr_in     (reg_addr),
        .reg_wdata_in    (reg_wdata),
        .reg_wr_in       (reg_wr),
        .reg_rd_in       (reg_rd),
        .reg_rdata_out   (reg_rdata),
        .receive_flag_out(flag),
        .receive_irq_out (irq)
    );

    aur_line_model u_tx (
        .clk_in  (clk_in),
        .tick_in (tick),
        .line_out(pin),
        .tick_lost_out(tick_lost)
    );

    // ************************************************************
    // Bus and checking tasks
    // ************************************************************
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : expect_reg

    task automatic wait_flag();
        for (int i = 0; i < 3000 && flag !== 1'b1; i++)
            @(posedge clk_in);
        #1;
        if (flag !== 1'b1)
        begin
            num_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, flag, 1'b1);
            final_report();
        end
    endtask : wait_flag

    // Missing baud tick is flagged by the line model: count it and stop
    always @(posedge clk_in)
    begin
        if (tick_lost === 1'b1)
        begin
            num_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, 1'b0, 1'b1);
            final_report();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        expect_reg(CTL, 8'h00);
        expect_reg(STA, 8'h08);
        expect_reg(8'h0C, 8'h00);
        u_tx.send_char(9'h055, 1'b0, 1'b1);
        check({7'h00, flag}, 8'h00);
        reg_write(CTL, 8'h01);
        reg_write(CTL, 8'h03);
        expect_reg(CTL, 8'h03);
        fork
            u_tx.send_char(9'h0A5, 1'b0, 1'b1);
            begin
                repeat (200) @(posedge clk_in);
                expect_reg(STA, 8'h00);
            end
        join
        wait_flag();
        check({7'h00, irq}, 8'h00);
        reg_write(STA, 8'hFF);
        expect_reg(STA, 8'h18);
        expect_reg(DAT, 8'hA5);
        check({7'h00, flag}, 8'h00);
        u_tx.glitch();
        check({7'h00, flag}, 8'h00);
        expect_reg(STA, 8'h08);
        // Bad stop followed directly by a good character
        u_tx.send_char(9'h03C, 1'b0, 1'b0);
        u_tx.send_char(9'h05A, 1'b0, 1'b1);
        expect_reg(STA, 8'h1C);
        check({7'h00, irq}, 8'h00);
        expect_reg(DAT, 8'h3C);
        expect_reg(STA, 8'h18);
        expect_reg(DAT, 8'h5A);
        // Third character completes with the store full
        u_tx.send_char(9'h011, 1'b0, 1'b1);
        u_tx.send_char(9'h022, 1'b0, 1'b1);
        u_tx.send_char(9'h033, 1'b0, 1'b1);
        expect_reg(STA, 8'h1A);
        expect_reg(DAT, 8'h11);
        expect_reg(DAT, 8'h22);
        u_tx.send_char(9'h044, 1'b0, 1'b1);
        check({7'h00, flag}, 8'h00);
        expect_reg(STA, 8'h0A);
        reg_write(CTL, 8'h01);
        reg_write(CTL, 8'h03);
        expect_reg(STA, 8'h08);
        u_tx.send_char(9'h044, 1'b0, 1'b1);
        expect_reg(DAT, 8'h44);
        // Receive disable keeps framing, port disable clears it
        u_tx.send_char(9'h066, 1'b0, 1'b0);
        reg_write(CTL, 8'h01);
        expect_reg(STA, 8'h0C);
        check({7'h00, flag}, 8'h00);
        reg_write(CTL, 8'h00);
        expect_reg(STA, 8'h08);
        reg_write(CTL, 8'h03);
        check({7'h00, flag}, 8'h00);
        u_tx.send_char(9'h077, 1'b0, 1'b1);
        wait_flag();
        for (int i = 0; i < 4; i++)
        begin
            reg_write(CTL, masks[i]);
            #1;
            check({7'h00, irq}, {7'h00, i == 3});
        end
        reg_write(CTL, 8'h03);
        expect_reg(DAT, 8'h77);
        reg_write(CTL, 8'h07);
        u_tx.send_char(9'h15A, 1'b1, 1'b1);
        expect_reg(STA, 8'h19);
        expect_reg(DAT, 8'h5A);
        u_tx.send_char(9'h033, 1'b1, 1'b1);
        expect_reg(STA, 8'h18);
        expect_reg(DAT, 8'h33);
        reg_write(CTL, 8'h0F);
        u_tx.send_char(9'h077, 1'b1, 1'b1);
        check({7'h00, flag}, 8'h00);
        u_tx.send_char(9'h142, 1'b1, 1'b1);
        expect_reg(STA, 8'h19);
        expect_reg(DAT, 8'h42);
        reg_write(CTL, 8'h07);
        u_tx.send_char(9'h099, 1'b1, 1'b1);
        expect_reg(STA, 8'h18);
        expect_reg(DAT, 8'h99);
        final_report();
    end
endmodule : aur_receiver_test
